// ===== core/line_loop_defs.svh
`ifndef LINE_LOOP_DEFS_SVH
`define LINE_LOOP_DEFS_SVH
// Byte offsets of the registers on the bus.
`define OFS_CONTROL    8'h00
`define OFS_STATUS     8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK   8'h0C
// Status and interrupt bit positions.
`define BIT_PATTERN_LOCK 0
`define BIT_SIGNAL_LOSS  1
`define BIT_LOOP_CODE    3
// Control register fields.
`define BIT_MODE_LO      0
`define BIT_MODE_HI      1
`define BIT_SINGLE_RAIL  2
`define CONTROL_RESET    8'h00
`define MASK_RESET       8'h00
`define STATUS_USED      8'h0B
// Persistence interval.
`define HOLD_TIME_S      5
`define CLOCK_HZ         200000000
`define HOLD_CYCLES      (`HOLD_TIME_S * `CLOCK_HZ)
`define CODE_UP          5'h01
`define CODE_DOWN        3'h1
`endif

// ===== core/line_loop_pkg.sv
package line_loop_pkg;
  typedef enum logic [1:0] {
    WATCH_IDLE = 2'b00,
    WATCH_UP   = 2'b01,
    WATCH_DOWN = 2'b10
  } watch_type;
endpackage

// ===== core/pattern_watch.sv
`timescale 1ns/1ps
`default_nettype none
// Tracks whether the last bits form a repeating code of the given period.
module pattern_watch (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       bitValid,
  input  wire logic       rxBit,
  input  wire logic       lookDown,
  output logic            upSeen,
  output logic            downSeen
);
  typedef struct packed {
    logic [9:0] hist;
    logic [3:0] fill;
    logic       up;
    logic       down;
  } watch_state_type;

  watch_state_type s_q;
  watch_state_type s_d;

  // Match any rotation of the code, since alignment to the line is unknown.
  function automatic logic rot5(input logic [4:0] w);
    rot5 = (w == 5'h01) || (w == 5'h02) || (w == 5'h04) || (w == 5'h08) || (w == 5'h10);
  endfunction

  function automatic logic rot3(input logic [2:0] w);
    rot3 = (w == 3'h1) || (w == 3'h2) || (w == 3'h4);
  endfunction

  always_comb begin
    s_d = s_q;
    if (bitValid) begin
      s_d.hist = {s_q.hist[8:0], rxBit};
      if (s_q.fill != 4'hA) begin
        s_d.fill = s_q.fill + 4'h1;
      end
      // A code holds when the window is periodic and one rotation matches.
      s_d.up = (s_q.fill >= 4'h9) && rot5(s_d.hist[4:0]) && (s_d.hist[9:5] == s_d.hist[4:0]); // R14
      s_d.down = (s_q.fill >= 4'h5) && rot3(s_d.hist[2:0]) && (s_d.hist[5:3] == s_d.hist[2:0]);
    end
    if (lookDown) begin
      s_d.up = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign upSeen   = s_q.up;
  assign downSeen = s_q.down;
endmodule
`default_nettype wire

// ===== core/line_loop_code_status.sv
`timescale 1ns/1ps
`include "line_loop_defs.svh"
`default_nettype none
// How it works
// R1: Automatic mode clears flag, watches loop-up.
// R2: Loop-up held over five seconds sets flag.
// R3: Flag set activates loopback, watches loop-down.
// R4: Flag stays set while loopback active.
// R5: Loop-down 001 over five seconds releases loopback.
// R6: Loop-down clears flag, may raise interrupt.
// R7: Status bit 2 reads zero.
// R8: Status bit 1 shows loss of signal.
// R9: Loss-of-signal transitions interrupt when enabled.
// R10: Status bit 0 shows pattern lock.
// R11: Pattern-lock transitions interrupt when enabled.
// R12: Status registers work only in single rail.
// R13: Software also sets framer single rail.
// R14: Loop-up code is repeating 00001.
// R15: Loop-code flag transitions interrupt when enabled.
// R16: Line-clock counter restarts when pattern lost; the counter here counts clk cycles, not line bits.
module line_loop_code_status #(
  parameter longint HoldCycles = `HOLD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        rxValid,
  input  wire logic        rxBit,
  input  wire logic        signalLoss,
  input  wire logic        patternLock,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             remoteLoopback,
  output logic             irq
);
  typedef struct packed {
    line_loop_pkg::watch_type mode;
    logic [31:0] count;
    logic        loopFlag;
    logic        loopback;
    logic        lossQ;
    logic        lockQ;
    logic [7:0]  control;
    logic [7:0]  irqStatus;
    logic [7:0]  irqMask;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [31:0] rdata;
    logic        irqOut;
  } top_state_type;

  top_state_type s_q;
  top_state_type s_d;
  logic          upSeen;
  logic          downSeen;
  logic          autoMode;
  logic          singleRail;
  logic          held;
  logic [7:0]    statusWord;
  logic [7:0]    events;
  logic [7:0]    clearBits;
  logic          addrPhase;

  pattern_watch watch (
    .clk      (clk),
    .reset    (reset),
    .bitValid (rxValid),
    .rxBit    (rxBit),
    .lookDown (s_q.mode == line_loop_pkg::WATCH_DOWN),
    .upSeen   (upSeen),
    .downSeen (downSeen)
  );

  function automatic logic [31:0] readMux(input logic [7:0] a, input logic [7:0] ctl,
                                          input logic [7:0] st, input logic [7:0] is,
                                          input logic [7:0] im);
    case (a)
      `OFS_CONTROL:    readMux = {24'h000000, ctl};
      `OFS_STATUS:     readMux = {24'h000000, st};
      `OFS_IRQ_STATUS: readMux = {24'h000000, is};
      `OFS_IRQ_MASK:   readMux = {24'h000000, im};
      default:         readMux = 32'h00000000;
    endcase
  endfunction

  // Counted in clock cycles; a bit that breaks the awaited code starts the interval over.
  // The count stops at its top so that a very long hold can never wrap and look short.
  function automatic logic [31:0] persistCount(input logic        valid,
                                               input logic        seen,
                                               input logic [31:0] cnt);
    if (valid && !seen) begin
      persistCount = 32'h00000000;
    end else if (cnt == 32'hFFFFFFFF) begin
      persistCount = cnt;
    end else begin
      persistCount = cnt + 32'h00000001;
    end
  endfunction

  function automatic logic toggled(input logic nxt, input logic cur);
    toggled = (nxt != cur);
  endfunction

  // A new event in the same cycle as a software clear keeps its bit set.
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] clr,
                                     input logic [7:0] set);
    w1c = ((cur & ~clr) | set) & `STATUS_USED;
  endfunction

  always_comb begin
    autoMode   = s_q.control[`BIT_MODE_HI] && s_q.control[`BIT_MODE_LO];
    singleRail = s_q.control[`BIT_SINGLE_RAIL];
    held       = (s_q.count >= HoldCycles[31:0]);
    statusWord = 8'h00;
    // Bit 2 and the upper bits stay zero; outside single rail all read zero.
    if (singleRail) begin // R12
      statusWord[`BIT_LOOP_CODE]    = s_q.loopFlag;
      statusWord[`BIT_SIGNAL_LOSS]  = s_q.lossQ; // R8
      statusWord[`BIT_PATTERN_LOCK] = s_q.lockQ; // R10
    end
    statusWord = statusWord & `STATUS_USED; // R7
    addrPhase = hsel && hready && htrans[1];
    s_d = s_q;
    s_d.lossQ = signalLoss;
    s_d.lockQ = patternLock;

    case (s_q.mode)
      line_loop_pkg::WATCH_IDLE: begin
        s_d.count = 32'h00000000;
        if (autoMode) begin
          s_d.loopFlag = 1'b0; // R1
          s_d.mode     = line_loop_pkg::WATCH_UP; // R1
        end
      end
      line_loop_pkg::WATCH_UP: begin
        // Count only while the code persists, so a single bit error restarts the interval.
        s_d.count = persistCount(rxValid, upSeen, s_q.count); // R16 R14
        if (held && upSeen) begin // R2
          s_d.loopFlag = 1'b1; // R2
          s_d.loopback = 1'b1; // R3
          s_d.mode     = line_loop_pkg::WATCH_DOWN; // R3
          s_d.count    = 32'h00000000;
        end
      end
      line_loop_pkg::WATCH_DOWN: begin
        s_d.count = persistCount(rxValid, downSeen, s_q.count); // R16
        if (held && downSeen) begin // R5
          s_d.loopback = 1'b0; // R5
          s_d.loopFlag = 1'b0; // R6
          s_d.mode     = line_loop_pkg::WATCH_UP; // R4
          s_d.count    = 32'h00000000;
        end
      end
      default: begin
        s_d.mode = line_loop_pkg::WATCH_IDLE;
      end
    endcase
    // Leaving automatic mode drops the loopback and returns to idle; the flag keeps its value.
    if (!autoMode) begin
      s_d.mode     = line_loop_pkg::WATCH_IDLE;
      s_d.loopback = 1'b0;
    end

    events = 8'h00;
    events[`BIT_LOOP_CODE]    = toggled(s_d.loopFlag, s_q.loopFlag); // R15 R6
    events[`BIT_SIGNAL_LOSS]  = toggled(s_d.lossQ, s_q.lossQ); // R9
    events[`BIT_PATTERN_LOCK] = toggled(s_d.lockQ, s_q.lockQ); // R11
    if (!singleRail) begin // R12
      events = 8'h00;
    end

    clearBits = 8'h00;
    s_d.wrPend = addrPhase && hwrite;
    s_d.wrAddr = haddr;
    if (s_q.wrPend) begin
      case (s_q.wrAddr)
        `OFS_CONTROL:    s_d.control = hwdata[7:0];
        `OFS_IRQ_MASK:   s_d.irqMask = hwdata[7:0] & `STATUS_USED;
        `OFS_IRQ_STATUS: clearBits   = hwdata[7:0];
        default:         clearBits   = 8'h00;
      endcase
    end
    s_d.irqStatus = w1c(s_q.irqStatus, clearBits, events);
    if (addrPhase && !hwrite) begin
      s_d.rdata = readMux(haddr, s_d.control, statusWord, s_q.irqStatus, s_q.irqMask);
    end
    s_d.irqOut = |(s_d.irqStatus & s_d.irqMask); // R9 R11 R15
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q         <= '0;
      s_q.mode    <= line_loop_pkg::WATCH_IDLE;
      s_q.control <= `CONTROL_RESET;
      s_q.irqMask <= `MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata         = s_q.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign remoteLoopback = s_q.loopback;
  assign irq            = s_q.irqOut;
endmodule
`default_nettype wire

// ===== tb/line_loop_code_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
module line_loop_code_status_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic        signalLoss,
  input wire logic        patternLock,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        remoteLoopback,
  input wire logic        irq
);
  logic       wr_q, rd;
  logic [7:0] adr_q, ctl_q, msk_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  assign rd = hsel && htrans[1] && !hwrite && haddr == 8'h04;
  // Shadow copies of control and mask, so the properties know which events are live.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {wr_q, adr_q, ctl_q, msk_q} <= '0;
    end else begin
      wr_q <= hsel && htrans[1] && hwrite;
      adr_q <= haddr;
      if (wr_q && adr_q == 8'h00) ctl_q <= hwdata[7:0];
      if (wr_q && adr_q == 8'h0C) msk_q <= hwdata[7:0];
    end
  end
  a_spare_zero: assert property (rd |=> hrdata[31:4] == 28'h0 && !hrdata[2]) else $error("spare bits");
  a_rail_off: assert property (rd && !ctl_q[2] |=> hrdata == 32'h0) else $error("rail off");
  a_loss_read: assert property (rd && ctl_q[2] && $stable(signalLoss)
    |=> hrdata[1] == $past(signalLoss)) else $error("loss bit");
  a_lock_read: assert property (rd && ctl_q[2] && $stable(patternLock)
    |=> hrdata[0] == $past(patternLock)) else $error("lock bit");
  a_loss_irq: assert property (ctl_q[2] && msk_q[1] && $changed(signalLoss)
    |-> ##[0:2] irq) else $error("loss irq");
  a_lock_irq: assert property (ctl_q[2] && msk_q[0] && $changed(patternLock)
    |-> ##[0:2] irq) else $error("lock irq");
  a_loop_irq: assert property (ctl_q[2:0] == 3'h7 && msk_q[3] && $changed(remoteLoopback)
    |-> ##[0:2] irq) else $error("loop irq");
  a_manual_off: assert property (ctl_q[1:0] != 2'b11 |=> !remoteLoopback) else $error("loopback");
endmodule
bind line_loop_code_status line_loop_code_status_properties i_props (.clk, .reset, .hsel, .signalLoss,
  .patternLock, .haddr, .htrans, .hwrite, .hwdata, .hrdata, .remoteLoopback, .irq);
`default_nettype wire

// ===== tb/line_source.sv
`timescale 1ns/1ps
`default_nettype none
// Sends loop-up, loop-down, all ones or random bits; slow gives a bit every other clock.
module line_source (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [1:0] mode,
  input wire logic       slow,
  output logic           rxValid,
  output logic           rxBit
);
  logic [2:0] ph;
  logic       tog;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {ph, tog, rxValid, rxBit} <= '0;
    end else begin
      tog <= ~tog;
      rxValid <= !slow || tog;
      if (!slow || tog) begin
        ph <= (ph == (mode == 2'd1 ? 3'd4 : 3'd2)) ? 3'd0 : ph + 3'd1;
        rxBit <= mode == 2'd1 ? ph == 3'd4 : mode == 2'd2 ? ph == 3'd2 : mode == 2'd3 || 1'($urandom);
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/line_loop_code_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module line_loop_code_status_tb;
  logic        clk, reset, rxValid, rxBit, signalLoss, patternLock, slow, hsel, hwrite;
  logic        hreadyout, hresp, remoteLoopback, irq;
  logic [1:0]  htrans, mode, old, now;
  logic [2:0]  hsize;
  logic [7:0]  haddr, msk;
  logic [31:0] hwdata, hrdata, r;
  int          mismatches, nTests;
  line_source i_line_source (.clk, .reset, .mode, .slow, .rxValid, .rxBit);
  line_loop_code_status #(.HoldCycles(200)) i_line_loop_code_status (.clk, .reset, .rxValid, .rxBit,
    .signalLoss, .patternLock, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .remoteLoopback, .irq);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] want);
    nTests++;
    if (got !== want) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", s, want, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'b10, a};
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    {htrans, hwdata} <= {2'b00, d};
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    q = hrdata;
    if (n >= 50) begin
      mismatches++;
      test_done;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [31:0] expStat(input logic lp, input logic [1:0] ll);
    return {28'h0, lp, 1'b0, ll};
  endfunction
  initial begin
    {reset, slow, hsel, hwrite, signalLoss, patternLock} = 6'h20;
    {mode, htrans, haddr, hwdata, mismatches, nTests} = '0;
    hsize = 3'h2;
    void'($urandom(32'h5CF36376));
    wt(5);
    reset <= 1'b0;
    {signalLoss, patternLock} <= 2'b11;
    wt(3);
    for (int a = 0; a < 5; a++) begin
      xfer(0, 8'(a * 4), 0, r);
      chk("reset", r, 32'h0);
      chk("okay", 32'(hresp), 32'h0);
    end
    $display("reset test done");
    xfer(1, 8'h00, 32'h04, r);
    xfer(1, 8'h08, 32'hFF, r);
    repeat (12) begin
      msk = 8'($urandom) & 8'h0B;
      xfer(1, 8'h0C, {24'h0, msk}, r);
      old = {signalLoss, patternLock};
      now = 2'($urandom);
      {signalLoss, patternLock} <= now;
      wt(3);
      xfer(0, 8'h04, 0, r);
      chk("status", r, expStat(0, now));
      xfer(0, 8'h08, 0, r);
      chk("events", r, {30'h0, old ^ now});
      chk("irq", 32'(irq), 32'(|({6'h00, old ^ now} & msk)));
      xfer(1, 8'h08, 32'hFF, r);
      wt(2);
      chk("irq clear", 32'(irq), 32'h0);
    end
    $display("event test done");
    {signalLoss, patternLock, mode, slow} <= 5'h03;
    wt(3);
    xfer(1, 8'h08, 32'hFF, r);
    xfer(1, 8'h0C, 32'h08, r);
    for (int m = 4; m < 7; m++) begin
      xfer(1, 8'h00, 32'(m), r);
      wt(300);
      chk("manual", 32'(remoteLoopback), 32'h0);
    end
    xfer(1, 8'h00, 32'h07, r);
    wt(150);
    mode <= 2'd3;
    wt(5);
    mode <= 2'd1;
    wt(150);
    chk("restart", 32'(remoteLoopback), 32'h0);
    wt(150);
    chk("loop up", 32'(remoteLoopback), 32'h1);
    xfer(0, 8'h04, 0, r);
    chk("flag", r, expStat(1, 0));
    mode <= 2'd3;
    wt(300);
    chk("held", 32'(remoteLoopback), 32'h1);
    xfer(0, 8'h08, 0, r);
    chk("up event", r, 32'h08);
    xfer(1, 8'h08, 32'hFF, r);
    mode <= 2'd2;
    wt(300);
    chk("loop down", 32'(remoteLoopback), 32'h0);
    xfer(0, 8'h04, 0, r);
    chk("flag clear", r, expStat(0, 0));
    chk("down irq", 32'(irq), 32'h1);
    $display("loop test done");
    test_done;
  end
endmodule
`default_nettype wire
